// File: cdm_pkg.sv
// package for the core data memory, status flags and interrupt control
package cdm_pkg;
  localparam logic [6:0] CDM_ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] CDM_ADDR_POINTER = 7'h01;
  localparam logic [6:0] CDM_ADDR_ACC = 7'h05;
  localparam logic [6:0] CDM_ADDR_PCL = 7'h06;
  localparam logic [6:0] CDM_ADDR_LOOKUP_PTR = 7'h07;
  localparam logic [6:0] CDM_ADDR_LOOKUP_HIGH = 7'h08;
  localparam logic [6:0] CDM_ADDR_WDT_SEL = 7'h09;
  localparam logic [6:0] CDM_ADDR_STATUS = 7'h0a;
  localparam logic [6:0] CDM_ADDR_IRQ_CTRL = 7'h0b;
  localparam logic [6:0] CDM_ADDR_COUNT_VAL = 7'h0d;
  localparam logic [6:0] CDM_ADDR_COUNT_SETUP = 7'h0e;
  localparam logic [6:0] CDM_ADDR_PORT_A = 7'h12;
  localparam logic [6:0] CDM_ADDR_PORT_A_DIR = 7'h13;
  localparam logic [6:0] CDM_ADDR_PORT_B = 7'h14;
  localparam logic [6:0] CDM_ADDR_PORT_B_DIR = 7'h15;
  localparam logic [6:0] CDM_ADDR_PORT_C = 7'h16;
  localparam logic [6:0] CDM_ADDR_PORT_C_DIR = 7'h17;
  localparam logic [6:0] CDM_RAM_FIRST = 7'h20;
  localparam logic [6:0] CDM_RAM_LAST = 7'h7f;
  localparam int CDM_RAM_WORDS = 96;
  // status bit positions
  localparam int CDM_ST_CARRY = 0;
  localparam int CDM_ST_HALF = 1;
  localparam int CDM_ST_ZERO = 2;
  localparam int CDM_ST_WRAP = 3;
  localparam int CDM_ST_PDOWN = 4;
  localparam int CDM_ST_EXPIRY = 5;
  // irq control bit positions
  localparam int CDM_IC_GLOBAL = 0;
  localparam int CDM_IC_PIN_EN = 1;
  localparam int CDM_IC_CNT_EN = 2;
  localparam int CDM_IC_PIN_PEND = 4;
  localparam int CDM_IC_CNT_PEND = 5;
  localparam logic [7:0] CDM_PTR_TOP_BIT = 8'h80;
  localparam logic [7:0] CDM_RESET_BYTE = 8'h00;
  localparam logic [10:0] CDM_VEC_PIN = 11'h004;
  localparam logic [10:0] CDM_VEC_COUNT = 11'h008;
  localparam int CDM_STACK_DEPTH = 2;

  // alu operation codes offered by the execution logic
  typedef enum logic [3:0] {
    CDM_ALU_PASS = 4'h0,
    CDM_ALU_ADD = 4'h1,
    CDM_ALU_ADC = 4'h2,
    CDM_ALU_SUB = 4'h3,
    CDM_ALU_SBC = 4'h4,
    CDM_ALU_AND = 4'h5,
    CDM_ALU_OR = 4'h6,
    CDM_ALU_XOR = 4'h7,
    CDM_ALU_CPL = 4'h8,
    CDM_ALU_INC = 4'h9,
    CDM_ALU_DEC = 4'ha,
    CDM_ALU_RLC = 4'hb,
    CDM_ALU_RRC = 4'hc,
    CDM_ALU_RL = 4'hd,
    CDM_ALU_RR = 4'he
  } cdm_alu_op_t;

  // one data access from execution logic
  typedef struct packed {
    logic rd;
    logic wr;
    logic bit_set;
    logic bit_clr;
    logic [2:0] bit_idx;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cdm_access_t;

  // alu operation and operands to be turned into a result and flags
  typedef struct packed {
    logic upd;
    cdm_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } cdm_alu_req_t;

  // control-flow events from execution logic
  typedef struct packed {
    logic isr_exit_reenable;
    logic subroutine_exit_plain;
    logic call_op;
    logic watchdog_clear_op;
    logic halt_op;
    logic wdt_timeout;
    logic instr_boundary;
  } cdm_events_t;
endpackage

// File: cdm_core.sv
// data memory, status flags and two-source interrupt control of the core
`timescale 1ns/1ps
module cdm_core
  import cdm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input cdm_access_t acc_req,
  input cdm_alu_req_t alu_req,
  input cdm_events_t events,
  input wire logic [7:0] lookup_high_byte,
  input wire logic [7:0] pc_low_in,
  input wire logic [7:0] count_value_in,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_c_in,
  input wire logic irq_pin_n,
  input wire logic counter_overflow,
  input wire logic second_phase_pulse,
  output logic [7:0] rdata,
  output logic [7:0] alu_result,
  output logic [7:0] status_out,
  output logic [7:0] irq_ctrl_out,
  output logic [7:0] pc_low_wr_data,
  output logic pc_low_wr,
  output logic irq_take,
  output logic [10:0] irq_vector,
  output logic [7:0] lookup_pointer_out,
  output logic [7:0] watchdog_select_out,
  output logic [7:0] count_setup_out,
  output logic [7:0] count_value_wr_data,
  output logic count_value_wr
);

  logic [7:0] ram [CDM_RAM_WORDS]; // general purpose bytes
  logic [6:0] indirect_pointer; // seven stored bits only
  logic [7:0] accumulator;
  logic [7:0] lookup_pointer;
  logic [7:0] watchdog_select_reg;
  logic [7:0] count_setup_reg;
  logic [7:0] port_regs [6]; // data and direction for three ports
  logic carry_flag;
  logic nibble_half_flag;
  logic zero_flag;
  logic signed_wrap_flag;
  logic powerdown_flag;
  logic wdt_expiry_flag;
  logic global_irq_enable;
  logic pin_irq_enable;
  logic counter_irq_enable;
  logic pin_irq_pending;
  logic counter_irq_pending;
  logic pin_prev; // last sample of pin, for edge detect
  logic [1:0] stack_level; // tracked depth of the pc stack
  logic phase_armed; // a phase pulse has asked for evaluation

  logic [6:0] eff_addr; // address after indirect resolution
  logic eff_null; // indirect through pointer zero
  logic [7:0] cur_byte; // current value at effective address
  logic [7:0] next_byte; // value to write back
  logic do_write;
  logic [8:0] next_alu;
  logic next_half;
  logic next_wrap;
  logic pin_fall;
  logic stack_full;
  logic pin_go;
  logic cnt_go;

  // true when address falls into general ram
  function automatic logic is_ram(input logic [6:0] a);
    is_ram = (a >= CDM_RAM_FIRST) && (a <= CDM_RAM_LAST);
  endfunction

  // port register slot from address 12H..17H
  function automatic logic [2:0] port_slot(input logic [6:0] a);
    logic [6:0] d;
    d = a - CDM_ADDR_PORT_A;
    port_slot = d[2:0];
  endfunction

  // address resolution through the pointer
  always_comb begin
    if (acc_req.addr == CDM_ADDR_INDIRECT) begin
      eff_addr = indirect_pointer;
      eff_null = (indirect_pointer == CDM_ADDR_INDIRECT);
    end else begin
      eff_addr = acc_req.addr;
      eff_null = 1'b0;
    end
  end

  // read mux; reserved locations fall through to zero
  always_comb begin
    cur_byte = CDM_RESET_BYTE;
    if (eff_null) begin
      cur_byte = CDM_RESET_BYTE;
    end else if (is_ram(eff_addr)) begin
      cur_byte = ram[eff_addr - CDM_RAM_FIRST];
    end else begin
      unique case (eff_addr)
        CDM_ADDR_POINTER: cur_byte = CDM_PTR_TOP_BIT | {1'b0, indirect_pointer};
        CDM_ADDR_ACC: cur_byte = accumulator;
        CDM_ADDR_PCL: cur_byte = pc_low_in;
        CDM_ADDR_LOOKUP_PTR: cur_byte = lookup_pointer;
        CDM_ADDR_LOOKUP_HIGH: cur_byte = lookup_high_byte;
        CDM_ADDR_WDT_SEL: cur_byte = watchdog_select_reg;
        CDM_ADDR_STATUS: cur_byte = {2'b00, wdt_expiry_flag, powerdown_flag,
          signed_wrap_flag, zero_flag, nibble_half_flag, carry_flag};
        CDM_ADDR_IRQ_CTRL: cur_byte = {2'b00, counter_irq_pending, pin_irq_pending,
          1'b0, counter_irq_enable, pin_irq_enable, global_irq_enable};
        CDM_ADDR_COUNT_VAL: cur_byte = count_value_in;
        CDM_ADDR_COUNT_SETUP: cur_byte = count_setup_reg;
        CDM_ADDR_PORT_A: cur_byte = port_a_in;
        CDM_ADDR_PORT_B: cur_byte = port_b_in;
        CDM_ADDR_PORT_C: cur_byte = port_c_in;
        CDM_ADDR_PORT_A_DIR, CDM_ADDR_PORT_B_DIR, CDM_ADDR_PORT_C_DIR:
          cur_byte = port_regs[port_slot(eff_addr)];
        default: cur_byte = CDM_RESET_BYTE;
      endcase
    end
  end

  // write value: full byte or single bit set and clear
  always_comb begin
    next_byte = acc_req.wdata;
    if (acc_req.bit_set) begin
      next_byte = cur_byte | (8'h01 << acc_req.bit_idx);
    end else if (acc_req.bit_clr) begin
      next_byte = cur_byte & ~(8'h01 << acc_req.bit_idx);
    end
    do_write = (acc_req.wr | acc_req.bit_set | acc_req.bit_clr) & ~eff_null;
  end

  // alu arithmetic used for the flags
  always_comb begin
    next_alu = {1'b0, alu_req.a};
    next_half = nibble_half_flag;
    next_wrap = signed_wrap_flag;
    unique case (alu_req.op)
      CDM_ALU_ADD, CDM_ALU_ADC: begin
        next_alu = {1'b0, alu_req.a} + {1'b0, alu_req.b}
          + {8'h00, (alu_req.op == CDM_ALU_ADC) & carry_flag};
        next_half = ({1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]}
          + {4'h0, (alu_req.op == CDM_ALU_ADC) & carry_flag}) > 5'h0f;
        next_wrap = (alu_req.a[7] == alu_req.b[7]) & (next_alu[7] != alu_req.a[7]);
      end
      CDM_ALU_SUB, CDM_ALU_SBC: begin // carry here means no borrow
        next_alu = {1'b0, alu_req.a} + {1'b0, ~alu_req.b}
          + {8'h00, (alu_req.op == CDM_ALU_SUB) | carry_flag};
        next_half = ({1'b0, alu_req.a[3:0]} + {1'b0, ~alu_req.b[3:0]}
          + {4'h0, (alu_req.op == CDM_ALU_SUB) | carry_flag}) > 5'h0f;
        next_wrap = (alu_req.a[7] != alu_req.b[7]) & (next_alu[7] != alu_req.a[7]);
      end
      CDM_ALU_AND: next_alu = {carry_flag, alu_req.a & alu_req.b};
      CDM_ALU_OR: next_alu = {carry_flag, alu_req.a | alu_req.b};
      CDM_ALU_XOR: next_alu = {carry_flag, alu_req.a ^ alu_req.b};
      CDM_ALU_CPL: next_alu = {carry_flag, ~alu_req.a};
      CDM_ALU_INC: next_alu = {carry_flag, alu_req.a + 8'h01};
      CDM_ALU_DEC: next_alu = {carry_flag, alu_req.a - 8'h01};
      CDM_ALU_RLC: next_alu = {alu_req.a, carry_flag};
      CDM_ALU_RRC: next_alu = {alu_req.a[0], carry_flag, alu_req.a[7:1]};
      CDM_ALU_RL: next_alu = {carry_flag, alu_req.a[6:0], alu_req.a[7]};
      CDM_ALU_RR: next_alu = {carry_flag, alu_req.a[0], alu_req.a[7:1]};
      default: next_alu = {carry_flag, alu_req.a};
    endcase
  end

  // interrupt decision terms
  always_comb begin
    pin_fall = pin_prev & ~irq_pin_n;
    stack_full = (stack_level == 2'(CDM_STACK_DEPTH));
    pin_go = pin_irq_pending & pin_irq_enable & global_irq_enable & ~stack_full;
    cnt_go = counter_irq_pending & counter_irq_enable & global_irq_enable
      & ~stack_full & ~pin_go;
  end

  // general ram writes
  always_ff @(posedge clk_sys) begin
    if (ce && do_write && is_ram(eff_addr)) begin
      ram[eff_addr - CDM_RAM_FIRST] <= next_byte;
    end
  end

  // plain special registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      indirect_pointer <= 7'h00;
      accumulator <= CDM_RESET_BYTE;
      lookup_pointer <= CDM_RESET_BYTE;
      watchdog_select_reg <= CDM_RESET_BYTE;
      count_setup_reg <= CDM_RESET_BYTE;
      for (int i = 0; i < 6; i++) begin
        port_regs[i] <= CDM_RESET_BYTE;
      end
    end else if (ce && do_write) begin
      unique case (eff_addr)
        CDM_ADDR_POINTER: indirect_pointer <= next_byte[6:0];
        CDM_ADDR_ACC: accumulator <= next_byte;
        CDM_ADDR_LOOKUP_PTR: lookup_pointer <= next_byte;
        CDM_ADDR_WDT_SEL: watchdog_select_reg <= next_byte;
        CDM_ADDR_COUNT_SETUP: count_setup_reg <= next_byte;
        CDM_ADDR_PORT_A, CDM_ADDR_PORT_A_DIR, CDM_ADDR_PORT_B,
        CDM_ADDR_PORT_B_DIR, CDM_ADDR_PORT_C, CDM_ADDR_PORT_C_DIR:
          port_regs[port_slot(eff_addr)] <= next_byte;
        default: ; // other locations are held elsewhere or reserved
      endcase
    end
  end

  // pass-through strobes to the pc and counter, registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_low_wr <= 1'b0;
      pc_low_wr_data <= CDM_RESET_BYTE;
      count_value_wr <= 1'b0;
      count_value_wr_data <= CDM_RESET_BYTE;
    end else if (ce) begin
      pc_low_wr <= do_write && (eff_addr == CDM_ADDR_PCL);
      pc_low_wr_data <= next_byte;
      count_value_wr <= do_write && (eff_addr == CDM_ADDR_COUNT_VAL);
      count_value_wr_data <= next_byte;
    end
  end

  // arithmetic flags; an alu update wins over a plain write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      carry_flag <= 1'b0;
      nibble_half_flag <= 1'b0;
      zero_flag <= 1'b0;
      signed_wrap_flag <= 1'b0;
    end else if (ce) begin
      if (alu_req.upd) begin
        carry_flag <= next_alu[8];
        nibble_half_flag <= next_half;
        if (!(alu_req.op inside {CDM_ALU_RLC, CDM_ALU_RRC, CDM_ALU_RL, CDM_ALU_RR})) begin
          zero_flag <= (next_alu[7:0] == 8'h00);
        end
        signed_wrap_flag <= next_wrap;
      end else if (do_write && eff_addr == CDM_ADDR_STATUS) begin
        carry_flag <= next_byte[CDM_ST_CARRY];
        nibble_half_flag <= next_byte[CDM_ST_HALF];
        zero_flag <= next_byte[CDM_ST_ZERO];
        signed_wrap_flag <= next_byte[CDM_ST_WRAP];
      end
    end
  end

  // expiry and powerdown flags ignore ordinary writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdt_expiry_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end else if (ce) begin
      // timeout is the set event, so it wins over a clear
      if (events.wdt_timeout) begin
        wdt_expiry_flag <= 1'b1;
      end else if (events.watchdog_clear_op || events.halt_op) begin
        wdt_expiry_flag <= 1'b0;
      end
      if (events.halt_op) begin
        powerdown_flag <= 1'b1;
      end else if (events.watchdog_clear_op) begin
        powerdown_flag <= 1'b0;
      end
    end
  end

  // stack depth tracking; only the pc is pushed, by the sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stack_level <= 2'd0;
    end else if (ce) begin
      if (events.call_op || irq_take) begin
        if (!stack_full) begin // on a full stack a call loses the oldest entry
          stack_level <= stack_level + 2'd1;
        end
      end else if ((events.isr_exit_reenable || events.subroutine_exit_plain)
                   && stack_level != 2'd0) begin
        stack_level <= stack_level - 2'd1;
      end
    end
  end

  // phase sampling: pulse arms evaluation, taken at the next boundary
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_armed <= 1'b0;
      pin_prev <= 1'b1;
    end else if (ce) begin
      pin_prev <= irq_pin_n;
      if (second_phase_pulse) begin
        phase_armed <= 1'b1;
      end else if (events.instr_boundary) begin
        phase_armed <= 1'b0;
      end
    end
  end

  // interrupt control register, pending flags and acknowledge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      global_irq_enable <= 1'b0;
      pin_irq_enable <= 1'b0;
      counter_irq_enable <= 1'b0;
      pin_irq_pending <= 1'b0;
      counter_irq_pending <= 1'b0;
      irq_take <= 1'b0;
      irq_vector <= 11'h000;
    end else if (ce) begin
      irq_take <= 1'b0;
      if (do_write && eff_addr == CDM_ADDR_IRQ_CTRL) begin
        global_irq_enable <= next_byte[CDM_IC_GLOBAL];
        pin_irq_enable <= next_byte[CDM_IC_PIN_EN];
        counter_irq_enable <= next_byte[CDM_IC_CNT_EN];
        pin_irq_pending <= next_byte[CDM_IC_PIN_PEND];
        counter_irq_pending <= next_byte[CDM_IC_CNT_PEND];
      end
      if (events.isr_exit_reenable) begin
        global_irq_enable <= 1'b1;
      end
      // acknowledge only on a boundary after a phase pulse
      if (phase_armed && events.instr_boundary && !irq_take) begin
        if (pin_go) begin
          pin_irq_pending <= 1'b0;
          global_irq_enable <= 1'b0;
          irq_take <= 1'b1;
          irq_vector <= CDM_VEC_PIN;
        end else if (cnt_go) begin
          counter_irq_pending <= 1'b0;
          global_irq_enable <= 1'b0;
          irq_take <= 1'b1;
          irq_vector <= CDM_VEC_COUNT;
        end
      end
      // new events set last so they survive a same-cycle clear
      if (pin_fall) begin
        pin_irq_pending <= 1'b1;
      end
      if (counter_overflow) begin
        counter_irq_pending <= 1'b1;
      end
    end
  end

  // registered views for the execution logic
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= CDM_RESET_BYTE;
      alu_result <= CDM_RESET_BYTE;
      status_out <= CDM_RESET_BYTE;
      irq_ctrl_out <= CDM_RESET_BYTE;
      lookup_pointer_out <= CDM_RESET_BYTE;
      watchdog_select_out <= CDM_RESET_BYTE;
      count_setup_out <= CDM_RESET_BYTE;
    end else if (ce) begin
      rdata <= cur_byte;
      alu_result <= next_alu[7:0];
      status_out <= {2'b00, wdt_expiry_flag, powerdown_flag, signed_wrap_flag,
        zero_flag, nibble_half_flag, carry_flag};
      irq_ctrl_out <= {2'b00, counter_irq_pending, pin_irq_pending, 1'b0,
        counter_irq_enable, pin_irq_enable, global_irq_enable};
      lookup_pointer_out <= lookup_pointer;
      watchdog_select_out <= watchdog_select_reg;
      count_setup_out <= count_setup_reg;
    end
  end

endmodule

// File: cdm_core_chk.sv
// assertion checker for the data memory, status and interrupt block
`timescale 1ns/1ps
module cdm_core_chk
  import cdm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input cdm_access_t acc_req,
  input cdm_alu_req_t alu_req,
  input cdm_events_t events,
  input wire logic irq_pin_n,
  input wire logic [7:0] rdata,
  input wire logic [7:0] alu_result,
  input wire logic [7:0] status_out,
  input wire logic [7:0] irq_ctrl_out,
  input wire logic irq_take,
  input wire logic [10:0] irq_vector
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_status_top_zero: assert property (status_out[7:6] == 2'b00)
    else $error("status top bits not zero");
  a_pointer_top_one: assert property (acc_req.rd && ce && acc_req.addr == CDM_ADDR_POINTER
    |=> rdata[7])
    else $error("pointer top bit reads zero");
  a_reserved_reads_zero: assert property (acc_req.rd && ce && acc_req.addr inside
    {7'h02, 7'h03, 7'h04, 7'h0c, 7'h0f, 7'h10, 7'h11, [7'h18:7'h1f]}
    |=> rdata == 8'h00)
    else $error("reserved location reads nonzero");
  // zero flag lands one cycle after the result
  a_zero_flag_follows: assert property (alu_req.upd && ce && alu_req.op inside
    {CDM_ALU_ADD, CDM_ALU_SUB, CDM_ALU_AND}
    |=> ((alu_result == 8'h00) ##1 status_out[CDM_ST_ZERO])
    or ((alu_result != 8'h00) ##1 !status_out[CDM_ST_ZERO]))
    else $error("zero flag disagrees with result");
  a_status_write_keeps: assert property (acc_req.wr && ce && acc_req.addr == CDM_ADDR_STATUS
    && events == '0 |-> ##2 status_out[5:4] == $past(status_out[5:4]))
    else $error("status write changed expiry or powerdown");
  a_pin_edge_pends: assert property ($fell(irq_pin_n) && ce
    |-> ##[2:3] irq_ctrl_out[CDM_IC_PIN_PEND])
    else $error("pin edge not recorded");
  a_take_one_cycle: assert property (irq_take |=> !irq_take)
    else $error("irq take longer than one cycle");
  a_take_needs_global: assert property (irq_take |-> irq_ctrl_out[CDM_IC_GLOBAL])
    else $error("irq taken with global enable off");
  a_pin_wins: assert property (irq_take && irq_ctrl_out[CDM_IC_PIN_PEND]
    && irq_ctrl_out[CDM_IC_PIN_EN] |-> irq_vector == CDM_VEC_PIN)
    else $error("pin request not given priority");
  a_counter_vector: assert property (irq_take && irq_vector == CDM_VEC_COUNT
    |-> irq_ctrl_out[CDM_IC_CNT_PEND] && irq_ctrl_out[CDM_IC_CNT_EN])
    else $error("counter vector without enabled request");
endmodule

bind cdm_core cdm_core_chk u_chk (.clk_sys, .rst, .ce, .acc_req, .alu_req, .events,
  .irq_pin_n, .rdata, .alu_result, .status_out, .irq_ctrl_out, .irq_take, .irq_vector);

// File: cdm_exec_model.sv
// model of the instruction execution logic that drives the block
`timescale 1ns/1ps
module cdm_exec_model
  import cdm_pkg::*;
(
  input wire logic clk_sys,
  output cdm_access_t acc_req,
  output cdm_alu_req_t alu_req,
  output cdm_events_t events
);
  // idle until a task asks for something
  initial begin
    acc_req = '0;
    alu_req = '0;
    events = '0;
  end

  // one access held for exactly one rising edge
  task automatic acc(input cdm_access_t a);
    @(negedge clk_sys);
    acc_req <= a;
    @(negedge clk_sys);
    acc_req <= '0;
  endtask

  // one alu operation and its operands handed over for result and flag update
  task automatic alu(input cdm_alu_op_t op, input logic [7:0] a, input logic [7:0] b);
    @(negedge clk_sys);
    alu_req <= {1'b1, op, a, b};
    @(negedge clk_sys);
    alu_req <= '0;
  endtask

  // one-cycle control-flow event pulse
  task automatic ev(input cdm_events_t e);
    @(negedge clk_sys);
    events <= e;
    @(negedge clk_sys);
    events <= '0;
  endtask
endmodule

// File: cdm_core_bench.sv
// self-checking testbench for the data memory, status and interrupt block
`timescale 1ns/1ps
module cdm_core_bench;
  import cdm_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, irq_pin_n = 1'b1;
  logic counter_overflow = 1'b0, second_phase_pulse = 1'b0;
  logic [7:0] pc_low_in = 8'h11, lookup_high_byte = 8'h3c, count_value_in = 8'h22;
  logic [7:0] port_a_in = 8'h33, port_b_in = 8'h44, port_c_in = 8'h55;
  cdm_access_t acc_req;
  cdm_alu_req_t alu_req;
  cdm_events_t events;
  logic [7:0] rdata, alu_result, status_out, irq_ctrl_out;
  logic irq_take;
  logic [10:0] irq_vector;
  logic [7:0] pc_low_wr_data, count_value_wr_data;
  logic [7:0] lookup_pointer_out, watchdog_select_out, count_setup_out;
  logic pc_low_wr, count_value_wr;
  int n_errors = 0;
  int compares = 0;

  cdm_exec_model u_exec (.clk_sys, .acc_req, .alu_req, .events);
  cdm_core dut (.clk_sys, .rst, .ce, .acc_req, .alu_req, .events, .lookup_high_byte,
    .pc_low_in, .count_value_in, .port_a_in, .port_b_in, .port_c_in, .irq_pin_n,
    .counter_overflow, .second_phase_pulse, .rdata, .alu_result, .status_out,
    .irq_ctrl_out, .pc_low_wr_data, .pc_low_wr, .irq_take, .irq_vector,
    .lookup_pointer_out, .watchdog_select_out, .count_setup_out,
    .count_value_wr_data, .count_value_wr);

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_exec.acc({4'b0100, 3'h0, a, d});
  endtask

  // read answer stands once the access edge has passed
  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string what);
    u_exec.acc({4'b1000, 3'h0, a, 8'h00});
    chk(what, {3'h0, exp}, {3'h0, rdata});
  endtask

  task automatic pulse_in(input int which);
    @(negedge clk_sys);
    if (which == 0) second_phase_pulse = 1'b1;
    else counter_overflow = 1'b1;
    @(negedge clk_sys);
    second_phase_pulse = 1'b0;
    counter_overflow = 1'b0;
  endtask

  // phase pulse, then an instruction boundary; the take pulse stands one cycle after it
  task automatic step(input logic take, input logic [10:0] vec);
    pulse_in(0);
    u_exec.ev(7'h01);
    chk("irq_take", {10'h0, take}, {10'h0, irq_take});
    if (take) chk("irq_vector", vec, irq_vector);
  endtask

  // the result stands only for the cycle after the update, the flags a cycle later
  task automatic alu_chk(input cdm_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] res, input logic [3:0] exp);
    u_exec.alu(op, a, b);
    chk("alu result", {3'h0, res}, {3'h0, alu_result});
    @(negedge clk_sys);
    chk("flags", {7'h0, exp}, {7'h0, status_out[3:0]});
  endtask

  task automatic t_mem;
    wr(CDM_RAM_FIRST, 8'ha5);
    wr(CDM_RAM_LAST, 8'h5a);
    rd(CDM_RAM_FIRST, 8'ha5, "ram first");
    u_exec.acc({4'b0010, 3'h7, CDM_RAM_LAST, 8'h00});
    u_exec.acc({4'b0001, 3'h1, CDM_RAM_LAST, 8'h00});
    rd(CDM_RAM_LAST, 8'hd8, "bit ops");
    wr(7'h1f, 8'hff);
    rd(7'h1f, 8'h00, "reserved");
    rd(7'h02, 8'h00, "reserved");
  endtask

  task automatic t_ind;
    wr(CDM_ADDR_POINTER, 8'hff);
    rd(CDM_ADDR_POINTER, 8'hff, "pointer");
    wr(CDM_ADDR_POINTER, 8'ha1);
    wr(CDM_ADDR_INDIRECT, 8'h3e);
    rd(7'h21, 8'h3e, "indirect write");
    rd(CDM_ADDR_INDIRECT, 8'h3e, "indirect read");
    wr(CDM_ADDR_POINTER, 8'h00);
    rd(CDM_ADDR_POINTER, 8'h80, "pointer null");
    wr(CDM_ADDR_INDIRECT, 8'h77);
    rd(CDM_ADDR_INDIRECT, 8'h00, "indirect null");
  endtask

  // external values show at their addresses, the lookup byte refuses writes
  task automatic t_inputs;
    wr(CDM_ADDR_LOOKUP_HIGH, 8'h00);
    rd(CDM_ADDR_LOOKUP_HIGH, 8'h3c, "lookup high");
    rd(CDM_ADDR_PCL, 8'h11, "pc low");
    rd(CDM_ADDR_COUNT_VAL, 8'h22, "count");
    rd(CDM_ADDR_PORT_A, 8'h33, "port a");
    rd(CDM_ADDR_PORT_B, 8'h44, "port b");
    rd(CDM_ADDR_PORT_C, 8'h55, "port c");
    @(negedge clk_sys);
    lookup_high_byte = 8'hc3;
    port_a_in = 8'h0f;
    rd(CDM_ADDR_LOOKUP_HIGH, 8'hc3, "lookup high live");
    rd(CDM_ADDR_PORT_A, 8'h0f, "port a live");
  endtask

  // writes that leave the block as strobes or as register views
  task automatic t_outputs;
    wr(CDM_ADDR_PCL, 8'h9c);
    chk("pc low strobe", 11'h19c, {2'h0, pc_low_wr, pc_low_wr_data});
    wr(CDM_ADDR_COUNT_VAL, 8'h4b);
    chk("count strobe", 11'h14b, {2'h0, count_value_wr, count_value_wr_data});
    wr(CDM_ADDR_LOOKUP_PTR, 8'h61);
    wr(CDM_ADDR_WDT_SEL, 8'h07);
    wr(CDM_ADDR_COUNT_SETUP, 8'hc2);
    @(negedge clk_sys);
    chk("strobes idle", 11'h000, {9'h0, pc_low_wr, count_value_wr});
    chk("lookup ptr", 11'h061, {3'h0, lookup_pointer_out});
    chk("wdt select", 11'h007, {3'h0, watchdog_select_out});
    chk("count setup", 11'h0c2, {3'h0, count_setup_out});
  endtask

  // with the enable low nothing moves, writes and events included
  task automatic t_freeze;
    @(negedge clk_sys);
    ce = 1'b0;
    wr(CDM_RAM_FIRST, 8'h00);
    u_exec.ev(7'h04);
    @(negedge clk_sys);
    ce = 1'b1;
    rd(CDM_RAM_FIRST, 8'ha5, "frozen ram");
    rd(CDM_ADDR_STATUS, 8'h0f, "frozen status");
  endtask

  // flags read as {wrap, zero, half, carry}; rotates leave zero alone
  task automatic t_alu;
    alu_chk(CDM_ALU_XOR, 8'hff, 8'hff, 8'h00, 4'h4);
    alu_chk(CDM_ALU_RL, 8'h81, 8'h00, 8'h03, 4'h4);
    alu_chk(CDM_ALU_SBC, 8'h10, 8'h01, 8'h0e, 4'h1);
    alu_chk(CDM_ALU_ADC, 8'h0e, 8'h01, 8'h10, 4'h2);
    alu_chk(CDM_ALU_ADD, 8'h80, 8'h80, 8'h00, 4'hd);
    alu_chk(CDM_ALU_ADD, 8'h0f, 8'h01, 8'h10, 4'h2);
    alu_chk(CDM_ALU_SUB, 8'h05, 8'h03, 8'h02, 4'h3);
    alu_chk(CDM_ALU_SUB, 8'h03, 8'h05, 8'hfe, 4'h0);
    alu_chk(CDM_ALU_ADD, 8'h7f, 8'h01, 8'h80, 4'ha);
    alu_chk(CDM_ALU_RLC, 8'h80, 8'h00, 8'h00, 4'hb);
    alu_chk(CDM_ALU_RRC, 8'h00, 8'h00, 8'h80, 4'ha);
  endtask

  task automatic t_flags;
    u_exec.ev(7'h04);
    rd(CDM_ADDR_STATUS, 8'h1a, "halt");
    u_exec.ev(7'h02);
    rd(CDM_ADDR_STATUS, 8'h3a, "timeout");
    wr(CDM_ADDR_STATUS, 8'hff);
    rd(CDM_ADDR_STATUS, 8'h3f, "status write");
    u_exec.ev(7'h04);
    rd(CDM_ADDR_STATUS, 8'h1f, "halt clears expiry");
    u_exec.ev(7'h08);
    rd(CDM_ADDR_STATUS, 8'h0f, "watchdog clear");
  endtask

  task automatic t_irq;
    wr(CDM_ADDR_IRQ_CTRL, 8'h06);
    @(negedge clk_sys);
    irq_pin_n = 1'b0;
    pulse_in(1);
    irq_pin_n = 1'b1;
    step(1'b0, 11'h000);
    rd(CDM_ADDR_IRQ_CTRL, 8'h36, "both pending");
    wr(CDM_ADDR_IRQ_CTRL, 8'h37);
    step(1'b1, CDM_VEC_PIN);
    rd(CDM_ADDR_IRQ_CTRL, 8'h26, "pin serviced");
    u_exec.ev(7'h40);
    rd(CDM_ADDR_IRQ_CTRL, 8'h27, "isr exit");
    step(1'b1, CDM_VEC_COUNT);
    rd(CDM_ADDR_IRQ_CTRL, 8'h06, "counter serviced");
    u_exec.ev(7'h20);
    rd(CDM_ADDR_IRQ_CTRL, 8'h06, "plain return");
  endtask

  // two calls fill the stack; the request waits for a return
  task automatic t_stack;
    u_exec.ev(7'h10);
    u_exec.ev(7'h10);
    wr(CDM_ADDR_IRQ_CTRL, 8'h05);
    pulse_in(1);
    step(1'b0, 11'h000);
    u_exec.ev(7'h20);
    step(1'b1, CDM_VEC_COUNT);
    u_exec.ev(7'h40);
    u_exec.ev(7'h20);
  endtask

  task automatic final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    t_mem();
    t_ind();
    t_inputs();
    t_outputs();
    t_alu();
    t_flags();
    t_freeze();
    t_irq();
    t_stack();
    final_report();
  end

  // cuts a hang short well past the expected run length
  initial begin
    #50000;
    n_errors++;
    final_report();
  end
endmodule
